//--- fault_monitor_defines.vh
`ifndef FAULT_MONITOR_DEFINES_VH
`define FAULT_MONITOR_DEFINES_VH

// Response mode codes shared by the supply, temperature and gate monitors
`define MODE_IGNORE        3'h0
`define MODE_LATCH_HOLD    3'h5
`define MODE_MAX           3'h5

// Response mode codes that gate the outputs (modes 010..100)
`define MODE_CP_OFF        3'h4
`define MODE_PD_RELAY_OFF  3'h2
`define MODE_PD_OFF        3'h3

// Drain-source response codes
`define DRAIN_MODE_MAX     4'h9
`define DRAIN_MODE_IGNORE  4'h0

// Filter times in ns and their cycle counts at 100 MHz
`define CLK_PERIOD_NS      10
`define SUPPLY_FILT_NS     10000
`define TEMP_FILT_NS       20000
`define GATE_FILT_NS       2000
`define SUPPLY_FILT_CYC    (`SUPPLY_FILT_NS / `CLK_PERIOD_NS)
`define TEMP_FILT_CYC      (`TEMP_FILT_NS / `CLK_PERIOD_NS)
`define GATE_FILT_CYC      (`GATE_FILT_NS / `CLK_PERIOD_NS)

// Drain-source detection period choices in cycles, index 0..3
`define DRAIN_PER0_CYC     16'h0064
`define DRAIN_PER1_CYC     16'h00C8
`define DRAIN_PER2_CYC     16'h0190
`define DRAIN_PER3_CYC     16'h0320

`endif

//--- fault_filter.v
`timescale 1ns/1ns
`default_nettype none
// Comparator must stay high for count cycles before filt_out rises.
module fault_filter #(
    parameter CW = 16
) (
    input  wire          clk_sys,
    input  wire          reset_n,
    input  wire          raw_in,
    input  wire [CW-1:0] count,
    output reg           filt_out
);
    reg [CW-1:0] cnt_r;

    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cnt_r    <= {CW{1'b0}};
            filt_out <= 1'b0;
        end else if (!raw_in) begin
            cnt_r    <= {CW{1'b0}};
            filt_out <= 1'b0;
        end else if (cnt_r + {{(CW-1){1'b0}}, 1'b1} >= count) begin
            filt_out <= 1'b1;
        end else begin
            cnt_r <= cnt_r + {{(CW-1){1'b0}}, 1'b1};
        end
    end
endmodule // fault_filter
`default_nettype wire

//--- fault_latch.v
`timescale 1ns/1ns
`default_nettype none
// One latched status with its frozen response mode.
module fault_latch #(
    parameter MW = 3
) (
    input  wire          clk_sys,
    input  wire          reset_n,
    input  wire          active,
    input  wire          enable,
    input  wire [MW-1:0] mode_in,
    input  wire          clear,
    output reg           status,
    output reg  [MW-1:0] mode_eff
);
    // Mode tracks the host only while idle, so a change during a fault waits
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            status   <= 1'b0;
            mode_eff <= {MW{1'b0}};
        end else begin
            if (active && enable && mode_eff != {MW{1'b0}})
                status <= 1'b1;
            else if (clear && !active)
                status <= 1'b0;
            if (!status && !active)
                mode_eff <= mode_in;
        end
    end
endmodule // fault_latch
`default_nettype wire

//--- fault_monitor_response_logic.v
// What this block does
// - Amp supply overvoltage latches, indicator low unless 000
// - Six response modes per monitor, host selectable
// - Supply mode change waits for cleared fault
// - Mode 101 keeps pump and drivers off
// - Modes 001-100 resume, keep status and indicator
// - Clear ignored while fault still present
// - Supply status clear returns indicator high
// - Overtemperature latches, indicator low unless 000
// - Overtemp mode change waits for cleared fault
// - Overtemp mode 101 keeps outputs off
// - Overtemp status clear returns indicator high
// - Transistor fault select chooses drain reaction
// - Twelve thresholds, four periods per side
// - Disabled phase stops drain monitoring
// - Drain monitoring enabled per channel
// - Low side fault needs comparator and drive
// - High side fault needs comparator and drive
// - Drain modes are codes 0000 to 1001
// - Gate overvoltage flagged per transistor
// - Gate fault cuts charge pump in modes 010-101; per-channel enable
// - Gate filter sets flag, 000 ignores
// - Gate mode change waits for cleared channel
`timescale 1ns/1ns
`default_nettype none
`include "fault_monitor_defines.vh"
module fault_monitor_response_logic #(
    parameter CW = 16
) (
    input  wire        clk_sys,
    input  wire        reset_n,
    input  wire        amp_supply_ov_cmp,
    input  wire        overtemp_cmp,
    input  wire [2:0]  drain_low_cmp,
    input  wire [2:0]  drain_high_cmp,
    input  wire [5:0]  gate_ov_cmp,
    input  wire        low_u_drive_in,
    input  wire        low_v_drive_in,
    input  wire        low_w_drive_in,
    input  wire        high_u_drive_in,
    input  wire        high_v_drive_in,
    input  wire        high_w_drive_in,
    input  wire [2:0]  amp_supply_ov_response_mode,
    input  wire [2:0]  overtemp_response_mode,
    input  wire [2:0]  gate_ov_response_mode,
    input  wire [3:0]  low_side_drain_response_mode,
    input  wire [3:0]  high_side_drain_response_mode,
    input  wire [5:0]  high_side_drain_monitor_select,
    input  wire [5:0]  low_side_drain_monitor_select,
    input  wire [11:0] transistor_monitor_channel_enable,
    input  wire        clear_amp_supply_ov,
    input  wire        clear_overtemp,
    input  wire [5:0]  clear_gate_ov,
    input  wire [5:0]  clear_drain,
    output reg         fault_indicator_n,
    output reg         charge_pump_en,
    output reg         predriver_en,
    output reg  [2:0]  phase_drive_en,
    output reg         relay_en,
    output reg         amp_supply_ov_status,
    output reg         overtemp_status,
    output reg  [5:0]  gate_ov_channel_status,
    output reg  [5:0]  drain_fault_status,
    output reg  [3:0]  low_side_drain_threshold,
    output reg  [3:0]  high_side_drain_threshold
);
    // Channel bits: [2:0] low side U,V,W; [5:3] high side U,V,W.
    // Enable bits: [5:0] drain monitors, [11:6] gate monitors.

    // Response of a 3-bit mode while the fault is present or latched
    function [2:0] mode_kill; // {cp_off, pd_off, relay_off}
        input [2:0] m;
        input       present;
        input       latched;
        begin
            mode_kill = 3'h0;
            if (latched && m == `MODE_LATCH_HOLD)
                mode_kill = 3'h7;
            else if (present) begin
                case (m)
                    `MODE_PD_RELAY_OFF: mode_kill = 3'h3;
                    `MODE_PD_OFF:       mode_kill = 3'h2;
                    `MODE_CP_OFF:       mode_kill = 3'h7;
                    `MODE_LATCH_HOLD:   mode_kill = 3'h7;
                    default:            mode_kill = 3'h0;
                endcase
            end
        end
    endfunction

    // Clamp threshold select to the twelve legal codes
    function [3:0] thr_clamp;
        input [3:0] s;
        begin
            thr_clamp = (s > 4'hB) ? 4'hB : s;
        end
    endfunction

    function [CW-1:0] drain_period;
        input [1:0] p;
        begin
            case (p)
                2'h0:    drain_period = `DRAIN_PER0_CYC;
                2'h1:    drain_period = `DRAIN_PER1_CYC;
                2'h2:    drain_period = `DRAIN_PER2_CYC;
                default: drain_period = `DRAIN_PER3_CYC;
            endcase
        end
    endfunction

    localparam [CW-1:0] SUP_CYC  = `SUPPLY_FILT_CYC;
    localparam [CW-1:0] TEMP_CYC = `TEMP_FILT_CYC;
    localparam [CW-1:0] GATE_CYC = `GATE_FILT_CYC;

    wire       sup_f;
    wire       temp_f;
    wire [5:0] gate_f;
    wire [5:0] drain_f;
    wire       sup_st;
    wire       temp_st;
    wire [5:0] gate_st;
    wire [2:0] sup_mode;
    wire [2:0] temp_mode;
    wire [17:0] gate_mode;
    wire [5:0] drive_in;
    wire [5:0] drain_raw;
    reg  [5:0] drain_st_r;
    reg  [2:0] phase_off_r;
    reg  [3:0] low_mode_r;
    reg  [3:0] high_mode_r;

    assign drive_in = {high_w_drive_in, high_v_drive_in, high_u_drive_in,
                       low_w_drive_in, low_v_drive_in, low_u_drive_in};
    // Comparator counts only while its drive input is on and phase alive
    assign drain_raw = {drain_high_cmp, drain_low_cmp} & drive_in
                     & transistor_monitor_channel_enable[5:0]
                     & ~{phase_off_r, phase_off_r};

    fault_filter #(.CW(CW)) u_sup_filt (
        .clk_sys  (clk_sys),
        .reset_n  (reset_n),
        .raw_in   (amp_supply_ov_cmp),
        .count    (SUP_CYC),
        .filt_out (sup_f)
    );
    fault_filter #(.CW(CW)) u_temp_filt (
        .clk_sys  (clk_sys),
        .reset_n  (reset_n),
        .raw_in   (overtemp_cmp),
        .count    (TEMP_CYC),
        .filt_out (temp_f)
    );
    fault_latch #(.MW(3)) u_sup_latch (
        .clk_sys  (clk_sys),
        .reset_n  (reset_n),
        .active   (sup_f),
        .enable   (1'b1),
        .mode_in  (amp_supply_ov_response_mode),
        .clear    (clear_amp_supply_ov),
        .status   (sup_st),
        .mode_eff (sup_mode)
    );
    fault_latch #(.MW(3)) u_temp_latch (
        .clk_sys  (clk_sys),
        .reset_n  (reset_n),
        .active   (temp_f),
        .enable   (1'b1),
        .mode_in  (overtemp_response_mode),
        .clear    (clear_overtemp),
        .status   (temp_st),
        .mode_eff (temp_mode)
    );

    genvar g;
    generate
        for (g = 0; g < 6; g = g + 1) begin : gch
            fault_filter #(.CW(CW)) u_gate_filt (
                .clk_sys  (clk_sys),
                .reset_n  (reset_n),
                .raw_in   (gate_ov_cmp[g]),
                .count    (GATE_CYC),
                .filt_out (gate_f[g])
            );
            fault_latch #(.MW(3)) u_gate_latch (
                .clk_sys  (clk_sys),
                .reset_n  (reset_n),
                .active   (gate_f[g]),
                .enable   (transistor_monitor_channel_enable[6+g]),
                .mode_in  (gate_ov_response_mode),
                .clear    (clear_gate_ov[g]),
                .status   (gate_st[g]),
                .mode_eff (gate_mode[3*g+2:3*g])
            );
            fault_filter #(.CW(CW)) u_drain_filt (
                .clk_sys  (clk_sys),
                .reset_n  (reset_n),
                .raw_in   (drain_raw[g]),
                .count    (drain_period(g < 3 ? low_side_drain_monitor_select[5:4]
                                              : high_side_drain_monitor_select[5:4])),
                .filt_out (drain_f[g])
            );
        end
    endgenerate

    // Output kill vector, combined across monitors
    reg [2:0] kill;
    reg [2:0] drain_kill;
    reg       any_st;
    integer   i;
    // Separate loop index so each process drives only its own variable
    integer   j;
    always @* begin
        kill = mode_kill(sup_mode, sup_f, sup_st)
             | mode_kill(temp_mode, temp_f, temp_st);
        for (i = 0; i < 6; i = i + 1) begin
            // Gate faults act through the pump only: drivers lose supply
            if (mode_kill(gate_mode[3*i+:3], gate_f[i] & transistor_monitor_channel_enable[6+i],
                          gate_st[i]) != 3'h0)
                kill = kill | 3'h4;
        end
        drain_kill = 3'h0;
        for (i = 0; i < 3; i = i + 1) begin
            if (drain_st_r[i] || drain_st_r[i+3])
                drain_kill[i] = 1'b1;
        end
        any_st = sup_st | temp_st | (|gate_st) | (|drain_st_r);
    end

    // Drain faults: latched per channel, any mode 0001 to 1001 stops only that phase
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            drain_st_r  <= 6'h00;
            phase_off_r <= 3'h0;
            low_mode_r  <= 4'h0;
            high_mode_r <= 4'h0;
        end else begin
            // Codes above 1001 are treated as ignore
            low_mode_r  <= (low_side_drain_response_mode > `DRAIN_MODE_MAX) ?
                           `DRAIN_MODE_IGNORE : low_side_drain_response_mode;
            high_mode_r <= (high_side_drain_response_mode > `DRAIN_MODE_MAX) ?
                           `DRAIN_MODE_IGNORE : high_side_drain_response_mode;
            for (j = 0; j < 6; j = j + 1) begin
                if (drain_f[j] && ((j < 3 ? low_mode_r : high_mode_r) != `DRAIN_MODE_IGNORE))
                    drain_st_r[j] <= 1'b1;
                else if (clear_drain[j] && !drain_f[j])
                    drain_st_r[j] <= 1'b0;
            end
            // Every code 0001 to 1001 stops the faulty phase while its status is latched
            for (j = 0; j < 3; j = j + 1) begin
                if (drain_kill[j])
                    phase_off_r[j] <= 1'b1;
                else
                    phase_off_r[j] <= 1'b0;
            end
        end
    end

    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            fault_indicator_n         <= 1'b1;
            charge_pump_en            <= 1'b0;
            predriver_en              <= 1'b0;
            phase_drive_en            <= 3'h0;
            relay_en                  <= 1'b0;
            amp_supply_ov_status      <= 1'b0;
            overtemp_status           <= 1'b0;
            gate_ov_channel_status    <= 6'h00;
            drain_fault_status        <= 6'h00;
            low_side_drain_threshold  <= 4'h0;
            high_side_drain_threshold <= 4'h0;
        end else begin
            fault_indicator_n         <= ~any_st;
            charge_pump_en            <= ~kill[2];
            predriver_en              <= ~(kill[2] | kill[1]);
            phase_drive_en            <= ~(drain_kill | {3{kill[2] | kill[1]}});
            relay_en                  <= ~(kill[2] | kill[0]);
            amp_supply_ov_status      <= sup_st;
            overtemp_status           <= temp_st;
            gate_ov_channel_status    <= gate_st;
            drain_fault_status        <= drain_st_r;
            low_side_drain_threshold  <= thr_clamp(low_side_drain_monitor_select[3:0]);
            high_side_drain_threshold <= thr_clamp(high_side_drain_monitor_select[3:0]);
        end
    end
endmodule // fault_monitor_response_logic
`default_nettype wire

//--- fmr_checker.sv
`timescale 1ns/1ns
`default_nettype none
module fmr_checker (
    input wire logic        clk_sys,
    input wire logic        reset_n,
    input wire logic        amp_supply_ov_cmp,
    input wire logic        overtemp_cmp,
    input wire logic        low_u_drive_in,
    input wire logic        high_u_drive_in,
    input wire logic [2:0]  amp_supply_ov_response_mode,
    input wire logic [2:0]  gate_ov_response_mode,
    input wire logic [11:0] transistor_monitor_channel_enable,
    input wire logic        fault_indicator_n,
    input wire logic        charge_pump_en,
    input wire logic        predriver_en,
    input wire logic        amp_supply_ov_status,
    input wire logic        overtemp_status,
    input wire logic [5:0]  gate_ov_channel_status,
    input wire logic [5:0]  drain_fault_status
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    wire logic any_st = amp_supply_ov_status | overtemp_status | (|gate_ov_channel_status) | (|drain_fault_status);
    AST_IND_LOW: assert property (any_st |-> ##[0:1] !fault_indicator_n)
        else $error("indicator high while a status is latched");
    AST_IND_HIGH: assert property ((!any_st)[*2] |-> fault_indicator_n)
        else $error("indicator low with all statuses clear");
    AST_SUPPLY_HOLD: assert property ($rose(amp_supply_ov_status) && amp_supply_ov_cmp
        ##1 amp_supply_ov_cmp[*8] |-> amp_supply_ov_status)
        else $error("supply status lost while fault present");
    AST_TEMP_HOLD: assert property ($rose(overtemp_status) && overtemp_cmp
        ##1 overtemp_cmp[*8] |-> overtemp_status)
        else $error("overtemp status lost while fault present");
    AST_SUPPLY_KILL: assert property ($rose(amp_supply_ov_status) && amp_supply_ov_response_mode == 3'h5
        |-> ##1 (!charge_pump_en && !predriver_en))
        else $error("mode 5 supply fault left outputs on");
    AST_LS_DRIVE: assert property ((!low_u_drive_in)[*8] |=> !$rose(drain_fault_status[0]))
        else $error("low side fault latched without drive");
    AST_HS_DRIVE: assert property ((!high_u_drive_in)[*8] |=> !$rose(drain_fault_status[3]))
        else $error("high side fault latched without drive");
    AST_DRAIN_OFF: assert property ((!transistor_monitor_channel_enable[0])[*8]
        |=> !$rose(drain_fault_status[0]))
        else $error("disabled drain channel latched");
    AST_GATE_OFF: assert property ((!transistor_monitor_channel_enable[6])[*8]
        |=> !$rose(gate_ov_channel_status[0]))
        else $error("disabled gate channel latched");
    AST_GATE_PUMP: assert property ($rose(gate_ov_channel_status[0]) && gate_ov_response_mode == 3'h5
        |-> ##1 !charge_pump_en)
        else $error("gate fault left charge pump on");
    cover property ($rose(amp_supply_ov_status));
    cover property ($rose(drain_fault_status[0]));
    cover property ($rose(fault_indicator_n));
endmodule // fmr_checker
bind fault_monitor_response_logic fmr_checker chk_i (.*);
`default_nettype wire

//--- host_model.sv
`timescale 1ns/1ns
`default_nettype none
module host_model (
    input  wire logic       clk_sys,
    output var  logic [2:0] op_mode [0:2],
    output var  logic [3:0] drain_mode,
    output var  logic [5:0] sel,
    output var  logic [11:0] chan_en,
    output var  logic [13:0] clr
);
    // Index 0 supply, 1 temperature, 2 gate
    initial begin
        op_mode = '{3'h0, 3'h0, 3'h0};
        drain_mode = 4'h0;
        sel = 6'h00;
        chan_en = 12'hFFF;
        clr = 14'h0000;
    end
    task automatic set_mode(input int i, input logic [2:0] m);
        @(negedge clk_sys);
        op_mode[i] = m;
    endtask
    task automatic set_config(input logic [3:0] dm, input logic [5:0] s, input logic [11:0] en);
        @(negedge clk_sys);
        drain_mode = dm;
        sel = s;
        chan_en = en;
    endtask
    // Held one full cycle so the edge between sees it
    task automatic clear(input logic [13:0] mask);
        @(negedge clk_sys);
        clr = mask;
        @(negedge clk_sys);
        clr = 14'h0000;
    endtask
endmodule // host_model
`default_nettype wire

//--- testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic        clk_sys = 1'b0;
    logic        reset_n = 1'b0;
    logic        amp_cmp = 1'b0;
    logic        temp_cmp = 1'b0;
    logic [2:0]  dlo = 3'h0, dhi = 3'h0, drv_lo = 3'h0, drv_hi = 3'h0;
    logic [5:0]  gate_cmp = 6'h00;
    wire logic [2:0]  op_mode [0:2];
    wire logic [3:0]  drain_mode, lo_thr, hi_thr;
    wire logic [5:0]  sel, gate_st, drain_st;
    wire logic [11:0] chan_en;
    wire logic [13:0] clr;
    wire logic [2:0]  phase_en;
    wire logic        ind_n, cp_en, pd_en, relay_en, amp_st, temp_st;
    int fails = 0;
    int samples_checked = 0;
    int cyc = 0;
    always #5 clk_sys = ~clk_sys;
    host_model host (.clk_sys(clk_sys), .op_mode(op_mode), .drain_mode(drain_mode), .sel(sel),
        .chan_en(chan_en), .clr(clr));
    fault_monitor_response_logic dut (.clk_sys(clk_sys), .reset_n(reset_n), .amp_supply_ov_cmp(amp_cmp),
        .overtemp_cmp(temp_cmp), .drain_low_cmp(dlo), .drain_high_cmp(dhi), .gate_ov_cmp(gate_cmp),
        .low_u_drive_in(drv_lo[0]), .low_v_drive_in(drv_lo[1]), .low_w_drive_in(drv_lo[2]),
        .high_u_drive_in(drv_hi[0]), .high_v_drive_in(drv_hi[1]), .high_w_drive_in(drv_hi[2]),
        .amp_supply_ov_response_mode(op_mode[0]), .overtemp_response_mode(op_mode[1]),
        .gate_ov_response_mode(op_mode[2]), .low_side_drain_response_mode(drain_mode),
        .high_side_drain_response_mode(drain_mode), .high_side_drain_monitor_select(sel),
        .low_side_drain_monitor_select(sel), .transistor_monitor_channel_enable(chan_en),
        .clear_amp_supply_ov(clr[0]), .clear_overtemp(clr[1]), .clear_gate_ov(clr[7:2]),
        .clear_drain(clr[13:8]), .fault_indicator_n(ind_n), .charge_pump_en(cp_en), .predriver_en(pd_en),
        .phase_drive_en(phase_en), .relay_en(relay_en), .amp_supply_ov_status(amp_st),
        .overtemp_status(temp_st), .gate_ov_channel_status(gate_st), .drain_fault_status(drain_st),
        .low_side_drain_threshold(lo_thr), .high_side_drain_threshold(hi_thr));
    task summarize();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    function automatic logic stat(input int k);
        return (k == 0) ? amp_st : (k == 1) ? temp_st : gate_st[0];
    endfunction
    task automatic drive_cmp(input int k, input logic v);
        if (k == 0) amp_cmp = v;
        else if (k == 1) temp_cmp = v;
        else gate_cmp[0] = v;
    endtask
    // One monitor through a full fault cycle; k 0 supply, 1 temperature, 2 gate channel 0
    task automatic run_mon(input int k, input logic [2:0] m);
        int n;
        n = (k == 0) ? 1000 : (k == 1) ? 2000 : 200;
        host.set_mode(k, m);
        wait_n(3);
        drive_cmp(k, 1'b1);
        wait_n(n - 2);
        chk(stat(k), 8'h00);
        wait_n(6);
        chk(stat(k), m != 3'h0);
        chk(ind_n, m == 3'h0);
        if (k < 2 || m == 3'h5) chk(cp_en, m < 3'h4);
        if (k < 2) chk(pd_en, m < 3'h2);
        if (k < 2) chk(relay_en, m != 3'h2 && m < 3'h4);
        host.set_mode(k, (m == 3'h5) ? 3'h1 : 3'h5);
        host.clear(14'h0001 << k);
        chk(stat(k), m != 3'h0);
        drive_cmp(k, 1'b0);
        wait_n(8);
        chk(stat(k), m != 3'h0);
        chk(ind_n, m == 3'h0);
        chk(cp_en, m != 3'h5);
        chk(pd_en, m != 3'h5);
        host.clear(14'h0001 << k);
        wait_n(4);
        chk(stat(k), 8'h00);
        chk(ind_n, 8'h01);
        chk(cp_en, 8'h01);
    endtask
    task automatic run_drain();
        host.set_config(4'h1, 6'h0F, 12'hFFE);
        wait_n(4);
        chk(lo_thr, 8'h0B);
        chk(hi_thr, 8'h0B);
        dlo[0] = 1'b1;
        drv_lo[0] = 1'b1;
        wait_n(120);
        chk(drain_st, 8'h00);
        host.set_config(4'h1, 6'h0F, 12'hFFF);
        drv_lo[0] = 1'b0;
        wait_n(120);
        chk(drain_st, 8'h00);
        drv_lo[0] = 1'b1;
        wait_n(120);
        chk(drain_st, 8'h01);
        chk(phase_en[0], 8'h00);
        dhi[0] = 1'b1;
        drv_hi[0] = 1'b1;
        wait_n(120);
        chk(drain_st, 8'h01);
        {dlo, dhi, drv_lo, drv_hi} = 12'h000;
        host.clear(14'h3F00);
        wait_n(4);
        chk(drain_st, 8'h00);
        chk(phase_en, 8'h07);
        host.set_config(4'h0, 6'h00, 12'hFBF);
        dhi[1] = 1'b1;
        drv_hi[1] = 1'b1;
        gate_cmp[0] = 1'b1;
        wait_n(220);
        chk(drain_st, 8'h00);
        chk(gate_st, 8'h00);
        host.set_config(4'h9, 6'h00, 12'hFBF);
        wait_n(120);
        chk(drain_st, 8'h10);
        {dhi, drv_hi, gate_cmp} = 12'h000;
        host.clear(14'h3F00);
        wait_n(4);
        chk(drain_st, 8'h00);
    endtask
    // Generous over the roughly 20.5k cycles the run needs
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            fails++;
            summarize();
        end
    end
    initial begin
        wait_n(20);
        reset_n = 1'b1;
        wait_n(2);
        chk(ind_n, 8'h01);
        for (int k = 0; k < 3; k++)
            for (int m = 0; m < 6; m++)
                run_mon(k, m[2:0]);
        run_drain();
        summarize();
    end
endmodule // testbench
`default_nettype wire
